//--- swwd_ctrl.sv
`timescale 1ns/100ps
`include "swwd_defines.svh"
module swwd_ctrl #(
  parameter int unsigned TOUT_CYC = `SWWD_TOUT_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Core side
  input  wire logic        sleep_instr_i,
  input  wire logic        wdt_clear_instr_i,
  input  wire logic        watchdog_config_enable_i,
  input  wire logic        external_reset_pin_i,
  input  wire logic        external_reset_pin_en_i,
  input  wire logic        power_on_reset_i,
  input  wire logic        ext_edge_irq_i,
  input  wire logic [7:0]  pin_change_a_i,
  input  wire logic [7:0]  pin_change_b_i,
  input  wire logic [7:0]  periph_irq_1_i,
  input  wire logic [7:0]  periph_irq_2_i,
  input  wire logic [7:0]  port_out_i,
  input  wire logic [7:0]  port_oe_i,
  output logic      [7:0]  port_out_o,
  output logic      [7:0]  port_oe_o,
  output logic             core_clk_en_o,
  output logic             device_reset_o,
  output logic             irq_vector_o,
  output logic             analog_supply_en_o,
  output logic             adc_usable_o,
  output logic      [7:0]  analog_enable_o,
  output logic             asleep_o
);
  swwd_pkg::swwd_state_t state;
  logic [7:0]  core_status, interrupt_control;
  logic [7:0]  pin_change_enable_a, pin_change_enable_b;
  logic [7:0]  peripheral_irq_enable_1, peripheral_irq_enable_2;
  logic [7:0]  peripheral_irq_flag_1, peripheral_irq_flag_2;
  logic [3:0]  wd_cfg;
  logic [7:0]  analog_en;
  logic        adc_ref_analog_supply;
  logic [7:0]  pc_a_q, pc_b_q, port_out_q, port_oe_q;
  logic [6:0]  presc;
  logic [31:0] wd_cnt;
  logic        ap_valid, ap_write;
  logic [7:0]  ap_addr;
  logic        wr_hit;
  logic [7:0]  wdata;
  logic [7:0]  pc_a_evt, pc_b_evt;
  logic        pc_evt, wake_irq, wd_tick, wd_tout, wd_run;
  logic        sleep_go, sleep_nop, hard_wake, irq_wake, wd_clr;

  // Decode of one address-phase register select
  function automatic logic sel(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // AHB address phase capture; always zero wait states
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (hready_i) begin
      ap_valid <= hsel_i & htrans_i[1];
      ap_write <= hwrite_i;
      ap_addr  <= haddr_i[7:0];
    end
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign wr_hit      = ap_valid & ap_write;
  assign wdata       = hwdata_i[7:0];

  // Pin-change edges, enabled per pin
  assign pc_a_evt = (pin_change_a_i ^ pc_a_q) & pin_change_enable_a;
  assign pc_b_evt = (pin_change_b_i ^ pc_b_q) & pin_change_enable_b;
  assign pc_evt   = |{pc_a_evt, pc_b_evt};
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_a_q <= 8'h00;
      pc_b_q <= 8'h00;
    end else begin
      pc_a_q <= pin_change_a_i;
      pc_b_q <= pin_change_b_i;
    end
  end

  // individual enables gate wake, global enable ignored
  assign wake_irq =
    (interrupt_control[`SWWD_IC_INTE] & interrupt_control[`SWWD_IC_INTF]) |
    (interrupt_control[`SWWD_IC_IOCE] & interrupt_control[`SWWD_IC_IOCF]) |
    (interrupt_control[`SWWD_IC_PERIPHERAL_INTERRUPT_ENABLE] &
     |{peripheral_irq_flag_1 & peripheral_irq_enable_1,
       peripheral_irq_flag_2 & peripheral_irq_enable_2});

  // pending enabled flag turns sleep into a no-op
  assign sleep_nop = (state == swwd_pkg::SWWD_RUN) & sleep_instr_i & wake_irq;
  assign sleep_go  = (state == swwd_pkg::SWWD_RUN) & sleep_instr_i &
                     ~sleep_nop;
  assign hard_wake = power_on_reset_i |
                     (external_reset_pin_en_i & external_reset_pin_i);
  // irq or watchdog wake continues execution
  assign irq_wake  = (state == swwd_pkg::SWWD_SLEEP) & (wake_irq | wd_tout);

  assign wd_run = watchdog_config_enable_i;
  // power-of-two prescaler, ratio 2**field when assigned
  // Compare with >= so a ratio cut below the count ticks at once, no wrap
  assign wd_tick = ~wd_cfg[`SWWD_WC_PSA] ? 1'b1 :
                   (presc >= ((7'h01 << wd_cfg[2:0]) - 7'h01));
  assign wd_tout = wd_run & wd_tick & (wd_cnt == TOUT_CYC - 1);
  // clear on instruction, sleep entry and irq or time-out wake
  assign wd_clr  = wdt_clear_instr_i | sleep_go | irq_wake | ~wd_run;

  // Sleep state machine
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= swwd_pkg::SWWD_RUN;
    end else if (hard_wake) begin
      state <= swwd_pkg::SWWD_RUN;
    end else begin
      unique case (state)
        swwd_pkg::SWWD_RUN: begin
          if (sleep_go)
            state <= swwd_pkg::SWWD_SLEEP;
        end
        swwd_pkg::SWWD_SLEEP: begin
          if (irq_wake)
            state <= swwd_pkg::SWWD_WAKE;
        end
        swwd_pkg::SWWD_WAKE: begin
          state <= swwd_pkg::SWWD_RUN;
        end
      endcase
    end
  end

  // prescaler and counter; ratio may change at any time
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      presc  <= 7'h00;
      wd_cnt <= 32'h0;
    end else if (wd_clr | wd_tout) begin
      presc  <= 7'h00;
      wd_cnt <= 32'h0;
    end else if (wd_tick) begin
      presc  <= 7'h00;
      wd_cnt <= wd_cnt + 32'h1;
    end else begin
      presc  <= presc + 7'h01;
    end
  end

  // time-out while running resets; pin and power-on reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      device_reset_o <= 1'b0;
    else
      device_reset_o <= hard_wake |
                        (wd_tout & (state == swwd_pkg::SWWD_RUN));
  end

  // vector after the prefetched instruction only with global enable
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      irq_vector_o <= 1'b0;
    else
      irq_vector_o <= (state == swwd_pkg::SWWD_WAKE) &
                      interrupt_control[`SWWD_IC_GIE] & wake_irq;
  end

  // Status flags; hardware events win over a software write
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      core_status <= `SWWD_RST_STATUS;
    end else begin
      if (wr_hit & sel(ap_addr, `SWWD_ADDR_STATUS))
        core_status <= {wdata[7:5], core_status[4:3], wdata[2:0]};
      // sleep entry clears power-down, sets time-out
      if (sleep_go) begin
        core_status[`SWWD_ST_PD] <= 1'b0;
        core_status[`SWWD_ST_TO] <= 1'b1;
      end
      if (wd_tout)
        core_status[`SWWD_ST_TO] <= 1'b0;
      // Power-on restores both flags high
      if (power_on_reset_i) begin
        core_status[`SWWD_ST_PD] <= 1'b1;
        core_status[`SWWD_ST_TO] <= 1'b1;
      end
    end
  end

  // Interrupt control and flags; a new event wins over a clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_control     <= 8'h00;
      peripheral_irq_flag_1 <= 8'h00;
      peripheral_irq_flag_2 <= 8'h00;
    end else begin
      if (wr_hit & sel(ap_addr, `SWWD_ADDR_INTCTL))
        interrupt_control <= wdata;
      if (ext_edge_irq_i)
        interrupt_control[`SWWD_IC_INTF] <= 1'b1;
      if (pc_evt)
        interrupt_control[`SWWD_IC_IOCF] <= 1'b1;
      // Software may clear, but a pulse in the same cycle still sets
      if (wr_hit & sel(ap_addr, `SWWD_ADDR_PERIPHERAL_IRQ_FLAG_1))
        peripheral_irq_flag_1 <= wdata | periph_irq_1_i;
      else
        peripheral_irq_flag_1 <= peripheral_irq_flag_1 | periph_irq_1_i;
      if (wr_hit & sel(ap_addr, `SWWD_ADDR_PERIPHERAL_IRQ_FLAG_2))
        peripheral_irq_flag_2 <= (wdata | periph_irq_2_i) & 8'hdf;
      else
        peripheral_irq_flag_2 <= (peripheral_irq_flag_2 | periph_irq_2_i) &
                                 8'hdf;
    end
  end

  // Plain enable registers and watchdog config
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_change_enable_a     <= 8'h00;
      pin_change_enable_b     <= 8'h00;
      peripheral_irq_enable_1 <= 8'h00;
      peripheral_irq_enable_2 <= 8'h00;
      wd_cfg                  <= 4'(`SWWD_RST_WDCFG);
    end else if (wr_hit) begin
      if (sel(ap_addr, `SWWD_ADDR_PCEA))
        pin_change_enable_a <= wdata;
      if (sel(ap_addr, `SWWD_ADDR_PCEB))
        pin_change_enable_b <= wdata;
      if (sel(ap_addr, `SWWD_ADDR_PERIPHERAL_IRQ_ENABLE_1))
        peripheral_irq_enable_1 <= wdata;
      if (sel(ap_addr, `SWWD_ADDR_PERIPHERAL_IRQ_ENABLE_2))
        peripheral_irq_enable_2 <= wdata & 8'hdf;
      // prescaler reassignment allowed in any state
      if (sel(ap_addr, `SWWD_ADDR_WDCFG))
        wd_cfg <= wdata[3:0];
    end
  end

  // analog enables are software only; sleep never touches them
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_en    <= 8'h00;
      adc_ref_analog_supply <= 1'b1;
    end else if (wr_hit & sel(ap_addr, `SWWD_ADDR_ANAEN)) begin
      analog_en    <= wdata;
      adc_ref_analog_supply <= hwdata_i[8];
    end
  end

  // port drive frozen at sleep entry
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      port_out_q <= 8'h00;
      port_oe_q  <= 8'h00;
    end else if (state == swwd_pkg::SWWD_RUN) begin
      port_out_q <= port_out_i;
      port_oe_q  <= port_oe_i;
    end
  end
  assign port_out_o = port_out_q;
  assign port_oe_o  = port_oe_q;

  // core clock gated while asleep; entry clears the watchdog and alters the PD and TO flags
  assign asleep_o      = (state == swwd_pkg::SWWD_SLEEP);
  assign core_clk_en_o = ~asleep_o;
  // analog supply off in sleep; converter unusable on that reference
  assign analog_supply_en_o = ~asleep_o;
  assign adc_usable_o       = ~(asleep_o & adc_ref_analog_supply);
  assign analog_enable_o    = analog_en;

  // Read mux, combinational in the data phase from the captured address
  always_comb begin
    hrdata_o = 32'h0;
    if (ap_valid & ~ap_write) begin
      unique case (ap_addr)
        `SWWD_ADDR_STATUS: hrdata_o[7:0] = core_status;
        `SWWD_ADDR_INTCTL: hrdata_o[7:0] = interrupt_control;
        `SWWD_ADDR_PCEA:   hrdata_o[7:0] = pin_change_enable_a;
        `SWWD_ADDR_PCEB:   hrdata_o[7:0] = pin_change_enable_b;
        `SWWD_ADDR_PERIPHERAL_IRQ_ENABLE_1:   hrdata_o[7:0] = peripheral_irq_enable_1;
        `SWWD_ADDR_PERIPHERAL_IRQ_ENABLE_2:   hrdata_o[7:0] = peripheral_irq_enable_2;
        `SWWD_ADDR_PERIPHERAL_IRQ_FLAG_1:   hrdata_o[7:0] = peripheral_irq_flag_1;
        `SWWD_ADDR_PERIPHERAL_IRQ_FLAG_2:   hrdata_o[7:0] = peripheral_irq_flag_2;
        `SWWD_ADDR_WDCFG:  hrdata_o[3:0] = wd_cfg;
        `SWWD_ADDR_ANAEN:  hrdata_o[8:0] = {adc_ref_analog_supply, analog_en};
        `SWWD_ADDR_WDCNT:  hrdata_o      = wd_cnt;
        default:           hrdata_o      = 32'h0;
      endcase
    end
  end
endmodule // swwd_ctrl

//--- swwd_defines.svh
`ifndef SWWD_DEFINES_SVH
`define SWWD_DEFINES_SVH
`define SWWD_CLK_HZ          20000000
`define SWWD_TOUT_MS         18
`define SWWD_TOUT_CYC        ((`SWWD_CLK_HZ / 1000) * `SWWD_TOUT_MS)
// Byte addresses of the register words
`define SWWD_ADDR_STATUS     8'h00
`define SWWD_ADDR_INTCTL     8'h04
`define SWWD_ADDR_PCEA       8'h08
`define SWWD_ADDR_PCEB       8'h0c
`define SWWD_ADDR_PERIPHERAL_IRQ_ENABLE_1       8'h10
`define SWWD_ADDR_PERIPHERAL_IRQ_ENABLE_2       8'h14
`define SWWD_ADDR_PERIPHERAL_IRQ_FLAG_1       8'h18
`define SWWD_ADDR_PERIPHERAL_IRQ_FLAG_2       8'h1c
`define SWWD_ADDR_WDCFG      8'h20
`define SWWD_ADDR_ANAEN      8'h24
`define SWWD_ADDR_WDCNT      8'h28
// core_status field positions
`define SWWD_ST_TO           4
`define SWWD_ST_PD           3
// interrupt_control field positions
`define SWWD_IC_GIE          7
`define SWWD_IC_PERIPHERAL_INTERRUPT_ENABLE         6
`define SWWD_IC_INTE         4
`define SWWD_IC_IOCE         3
`define SWWD_IC_INTF         1
`define SWWD_IC_IOCF         0
// watchdog config word: bit 3 assigns prescaler, bits 2:0 ratio
`define SWWD_WC_PSA          3
`define SWWD_RST_STATUS      8'h18
`define SWWD_RST_WDCFG       8'h0f
`endif

//--- swwd_pkg.sv
package swwd_pkg;
  typedef enum logic [1:0] {
    SWWD_RUN,
    SWWD_SLEEP,
    SWWD_WAKE
  } swwd_state_t;
endpackage

//--- swwd_ctrl_monitor.sv
`timescale 1ns/100ps
module swwd_ctrl_monitor (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  input wire logic       power_on_reset_i,
  input wire logic       external_reset_pin_i,
  input wire logic       external_reset_pin_en_i,
  input wire logic       watchdog_config_enable_i,
  input wire logic [7:0] port_out_o,
  input wire logic [7:0] port_oe_o,
  input wire logic       core_clk_en_o,
  input wire logic       device_reset_o,
  input wire logic       analog_supply_en_o,
  input wire logic [7:0] analog_enable_o,
  input wire logic       asleep_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Edges of the sleep state
  sequence enter_s;
    !asleep_o ##1 asleep_o;
  endsequence
  sequence leave_s;
    asleep_o ##1 !asleep_o;
  endsequence
  // Leaving sleep with no reset source present on either cycle
  sequence soft_leave_s;
    asleep_o && !power_on_reset_i &&
    !(external_reset_pin_en_i && external_reset_pin_i) ##1
    !asleep_o && !power_on_reset_i &&
    !(external_reset_pin_en_i && external_reset_pin_i);
  endsequence
  // Sleep gates the core, freezes pins and drops analog power
  clk_gate_a: assert property (asleep_o |-> !core_clk_en_o)
    else $error("core clock runs while asleep");
  port_hold_a: assert property (asleep_o && $past(asleep_o) |->
    $stable(port_out_o) && $stable(port_oe_o))
    else $error("port drive moved while asleep");
  analog_off_a: assert property (asleep_o |-> !analog_supply_en_o)
    else $error("analog supply on while asleep");
  analog_keep_a: assert property (enter_s |-> $stable(analog_enable_o))
    else $error("analog enables changed on sleep entry");
  // Power-on reset leaves sleep; the reset pin gives a device reset
  por_wake_a: assert property (asleep_o && power_on_reset_i |->
    ##[0:4] !asleep_o)
    else $error("power-on reset did not wake");
  pin_reset_a: assert property (asleep_o && external_reset_pin_i &&
    external_reset_pin_en_i |-> ##[0:4] device_reset_o)
    else $error("reset pin did not reset");
  // Other wake sources resume with the clock back and no device reset
  wake_resume_a: assert property (soft_leave_s |-> core_clk_en_o &&
    !device_reset_o ##1 !device_reset_o)
    else $error("soft wake did not resume cleanly");
  reset_cause_a: assert property ($rose(device_reset_o) |->
    $past(watchdog_config_enable_i) || $past(power_on_reset_i) ||
    $past(external_reset_pin_i))
    else $error("device reset without a cause");
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
endmodule // swwd_ctrl_monitor
bind swwd_ctrl swwd_ctrl_monitor u_mon (.mclk_i, .rst_i, .hreadyout_o,
  .hresp_o, .power_on_reset_i, .external_reset_pin_i,
  .external_reset_pin_en_i, .watchdog_config_enable_i, .port_out_o,
  .port_oe_o, .core_clk_en_o, .device_reset_o, .analog_supply_en_o,
  .analog_enable_o, .asleep_o);

//--- swwd_core_model.sv
`timescale 1ns/100ps
module swwd_core_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       core_clk_en_i,
  output logic      [7:0] port_out_o,
  output logic      [7:0] port_oe_o
);
  // Drive moves every core cycle, so a pin that fails to freeze shows
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      port_out_o <= 8'h00;
      port_oe_o  <= 8'hf0;
    end else if (core_clk_en_i) begin
      port_out_o <= port_out_o + 8'h01;
      port_oe_o  <= ~port_oe_o;
    end
  end
endmodule // swwd_core_model

//--- swwd_ctrl_bench.sv
`timescale 1ns/100ps
`include "swwd_defines.svh"
module swwd_ctrl_bench;
  logic        mclk_i, rst_i, hsel_i, hwrite_i, sleep_instr_i;
  logic        wdt_clear_instr_i, watchdog_config_enable_i;
  logic        external_reset_pin_i, external_reset_pin_en_i;
  logic        power_on_reset_i, ext_edge_irq_i, hreadyout_o, hresp_o;
  logic        core_clk_en_o, device_reset_o, irq_vector_o, asleep_o;
  logic        analog_supply_en_o, adc_usable_o, seen, rst_seen;
  logic [1:0]  htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [7:0]  pin_change_a_i, periph_irq_1_i, port_out_i, port_oe_i;
  logic [7:0]  port_out_o, port_oe_o, analog_enable_o, held, held_oe;
  int          err_total, compares, cyc, n;

  swwd_ctrl #(.TOUT_CYC(20)) uut (.mclk_i, .rst_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .sleep_instr_i, .wdt_clear_instr_i, .watchdog_config_enable_i,
    .external_reset_pin_i, .external_reset_pin_en_i, .power_on_reset_i,
    .ext_edge_irq_i, .pin_change_a_i, .pin_change_b_i(8'h00),
    .periph_irq_1_i, .periph_irq_2_i(8'h00), .port_out_i, .port_oe_i,
    .port_out_o, .port_oe_o, .core_clk_en_o, .device_reset_o,
    .irq_vector_o, .analog_supply_en_o, .adc_usable_o, .analog_enable_o,
    .asleep_o);
  swwd_core_model core (.mclk_i, .rst_i, .core_clk_en_i(core_clk_en_o),
    .port_out_o(port_out_i), .port_oe_o(port_oe_i));

  // Clock, cycle ceiling and a sticky view of reset requests
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  always @(negedge mclk_i) if (device_reset_o === 1'b1) rst_seen = 1'b1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Single word transfer; each phase held until hready is seen high
  task automatic ahb(input logic w, input logic [7:0] a, input int d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic do_reset();
    @(posedge mclk_i) rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
  endtask
  task automatic sleep_op();
    @(posedge mclk_i) sleep_instr_i <= 1'b1;
    @(posedge mclk_i) sleep_instr_i <= 1'b0;
  endtask
  // Bounded wait on the sleep state, sampled mid-cycle
  task automatic wait_sleep(input logic s);
    n = 0;
    while (asleep_o !== s && n < 300) begin
      @(negedge mclk_i);
      n++;
    end
  endtask

  task automatic t_regs();
    ahb(0, `SWWD_ADDR_STATUS, 0);
    chk(rd, {24'h0, `SWWD_RST_STATUS});
    ahb(0, `SWWD_ADDR_WDCFG, 0);
    chk(rd, {24'h0, `SWWD_RST_WDCFG});
    ahb(1, 8'h3c, 32'h5a);
    ahb(0, 8'h3c, 0);
    chk(rd, 32'h0);
    ahb(1, `SWWD_ADDR_PCEA, 32'h5a);
    ahb(0, `SWWD_ADDR_PCEA, 0);
    chk(rd, 32'h5a);
    $display("test regs done");
  endtask
  task automatic t_pending();
    ahb(1, `SWWD_ADDR_INTCTL, 1 << `SWWD_IC_INTE);
    @(posedge mclk_i) ext_edge_irq_i <= 1'b1;
    @(posedge mclk_i) ext_edge_irq_i <= 1'b0;
    sleep_op();
    repeat (3) @(negedge mclk_i);
    ahb(0, `SWWD_ADDR_STATUS, 0);
    chk(32'(asleep_o), 0);
    chk(rd, {24'h0, `SWWD_RST_STATUS});
    $display("test pending done");
  endtask
  // Edge, pin-change and peripheral wakes; the last two vector
  task automatic t_wake();
    for (int k = 0; k < 3; k++) begin
      ahb(1, `SWWD_ADDR_ANAEN, 32'h1a5);
      ahb(1, `SWWD_ADDR_PERIPHERAL_IRQ_FLAG_1, 0);
      ahb(1, `SWWD_ADDR_PCEA, 1);
      ahb(1, `SWWD_ADDR_PERIPHERAL_IRQ_ENABLE_1, 1);
      ahb(1, `SWWD_ADDR_INTCTL, k == 0 ? 1 << `SWWD_IC_INTE :
        k == 1 ? 8'h88 : 8'hc0);
      sleep_op();
      wait_sleep(1'b1);
      held = port_out_o;
      held_oe = port_oe_o;
      @(posedge mclk_i) pin_change_a_i <= pin_change_a_i ^ 8'h02;
      repeat (3) @(negedge mclk_i);
      // Frozen, unpowered, deaf to masked pins
      chk(32'(core_clk_en_o), 0);
      chk(32'(port_out_o), 32'(held));
      chk(32'(port_oe_o), 32'(held_oe));
      chk(32'(analog_supply_en_o), 0);
      chk(32'(adc_usable_o), 0);
      chk(32'(analog_enable_o), 32'ha5);
      chk(32'(asleep_o), 1);
      @(posedge mclk_i);
      if (k == 0) ext_edge_irq_i <= 1'b1;
      if (k == 1) pin_change_a_i <= pin_change_a_i ^ 8'h01;
      if (k == 2) periph_irq_1_i <= 8'h01;
      @(posedge mclk_i) ext_edge_irq_i <= 1'b0;
      periph_irq_1_i <= 8'h00;
      seen = 1'b0;
      rst_seen = 1'b0;
      repeat (10) @(negedge mclk_i) seen = seen | irq_vector_o;
      ahb(0, `SWWD_ADDR_STATUS, 0);
      // Wake, vector only with global enable
      chk(32'(asleep_o), 0);
      chk(32'(seen), 32'(k != 0));
      chk(32'(rst_seen), 0);
      chk(rd & 32'h18, 32'h10);
    end
    $display("test wake done");
  endtask
  task automatic t_wdog();
    watchdog_config_enable_i <= 1'b0;
    do_reset();
    ahb(1, `SWWD_ADDR_WDCFG, 0);
    rst_seen = 1'b0;
    repeat (200) @(negedge mclk_i);
    chk(32'(rst_seen), 0);
    @(posedge mclk_i) watchdog_config_enable_i <= 1'b1;
    do_reset();
    ahb(1, `SWWD_ADDR_WDCFG, 0);
    rst_seen = 1'b0;
    repeat (10) begin
      repeat (8) @(posedge mclk_i);
      wdt_clear_instr_i <= 1'b1;
      @(posedge mclk_i) wdt_clear_instr_i <= 1'b0;
    end
    chk(32'(rst_seen), 0);
    sleep_op();
    wait_sleep(1'b1);
    wait_sleep(1'b0);
    ahb(0, `SWWD_ADDR_STATUS, 0);
    // Time-out in sleep wakes and clears the flag
    chk(32'(rst_seen), 0);
    chk(rd & 32'h18, 0);
    wait (rst_seen === 1'b1 || n > 299);
    for (int p = 0; p < 2; p++) begin
      do_reset();
      ahb(1, `SWWD_ADDR_WDCFG, p ? 32'h09 : 0);
      rst_seen = 1'b0;
      n = 0;
      while (rst_seen !== 1'b1 && n < 300) begin
        @(negedge mclk_i);
        n++;
      end
      // Running time-out resets, divider stretches it
      chk(32'(rst_seen), 1);
      chk(32'(p ? n > 30 && n < 50 : n < 30), 1);
    end
    @(posedge mclk_i) watchdog_config_enable_i <= 1'b0;
    $display("test watchdog done");
  endtask
  task automatic t_rwake();
    for (int k = 0; k < 2; k++) begin
      do_reset();
      sleep_op();
      wait_sleep(1'b1);
      rst_seen = 1'b0;
      @(posedge mclk_i) power_on_reset_i <= k == 0;
      external_reset_pin_i <= k == 1;
      external_reset_pin_en_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      power_on_reset_i <= 1'b0;
      external_reset_pin_i <= 1'b0;
      wait_sleep(1'b0);
      // Reset sources wake with a reset
      chk(32'(asleep_o), 0);
      chk(32'(rst_seen), 1);
    end
    $display("test reset wake done");
  endtask

  initial begin
    rst_i = 1'b1;
    {hsel_i, hwrite_i, sleep_instr_i, wdt_clear_instr_i} = 4'h0;
    {external_reset_pin_i, external_reset_pin_en_i} = 2'h0;
    {watchdog_config_enable_i, power_on_reset_i, ext_edge_irq_i} = 3'h0;
    {htrans_i, haddr_i, hwdata_i} = 66'h0;
    {pin_change_a_i, periph_irq_1_i} = 16'h0;
    do_reset();
    t_regs();
    t_pending();
    t_wake();
    t_wdog();
    t_rwake();
    end_sim();
  end
endmodule // swwd_ctrl_bench
